// file: rtl/rxe_pkg.sv
/*
 * rxe_pkg: constants for the reset and access fault exception sequencer.
 * Assumes a 32-bit APB register bus and one clock at 100 MHz.
 */
package rxe_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_SWORD   = 8'h08;
    localparam logic [7:0] REG_VBASE   = 8'h0c;
    localparam logic [7:0] REG_ISP     = 8'h10;
    localparam logic [7:0] REG_PC      = 8'h14;
    localparam logic [7:0] REG_XLAT    = 8'h18;
    localparam logic [7:0] REG_FADDR   = 8'h1c;
    localparam logic [7:0] REG_FSTAT   = 8'h20;
    localparam logic [7:0] REG_FPC     = 8'h24;
    localparam logic [7:0] REG_FSWORD  = 8'h28;
    // status word fields
    localparam int SW_TRACE_HIGH = 15;
    localparam int SW_TRACE_LOW  = 14;
    localparam int SW_SUPER      = 13;
    localparam int SW_MASTER     = 12;
    localparam int SW_IPM_LO     = 8;
    localparam logic [2:0] IPM_MAX = 3'h7;
    // translation control fields
    localparam int XL_ENABLE   = 15;
    localparam int XL_PAGE8K   = 14;
    localparam int XL_CACHE_I  = 4;
    localparam int XL_CACHE_D  = 5;
    localparam logic [15:0] SWORD_RST = 16'h2700;
    localparam logic [31:0] VBASE_RST = 32'h0000_0000;
    // vectors
    localparam logic [7:0] VEC_RESET_ISP = 8'h00;
    localparam logic [7:0] VEC_RESET_PC  = 8'h01;
    localparam logic [7:0] VEC_ACCESS    = 8'h02;
    localparam logic [2:0] PREFETCH_LW   = 3'h4;
    localparam logic [3:0] PST_RUN       = 4'h0;
    localparam logic [3:0] PST_EXC       = 4'h1;
    localparam logic [3:0] PST_HALT      = 4'h7;
    // access kinds
    localparam logic [1:0] AK_DATA_WR  = 2'h0;
    localparam logic [1:0] AK_DATA_RD  = 2'h1;
    localparam logic [1:0] AK_LINE_RD  = 2'h2;
    localparam logic [1:0] AK_PREFETCH = 2'h3;
    // system reset pulse width
    localparam int SYSTEM_RESET_OUTPUT_NS     = 5120;
    localparam int CLK_NS      = 10;
    localparam int SYSTEM_RESET_OUTPUT_CYCLES = SYSTEM_RESET_OUTPUT_NS / CLK_NS;

    typedef enum logic [2:0] {
        RXE_IDLE  = 3'b000,
        RXE_VISP  = 3'b001,
        RXE_VPC   = 3'b010,
        RXE_FILL  = 3'b011,
        RXE_RUN   = 3'b100,
        RXE_STACK = 3'b101,
        RXE_VACC  = 3'b110,
        RXE_HALT  = 3'b111
    } rxe_state_t;
endpackage : rxe_pkg

// file: rtl/rxe_seq.sv
/*
 * rxe_seq: reset exception and access fault exception sequencer.
 * Assumes a memory port that answers each read with mem_done or
 * bus_error_acknowledge, and an APB master for the registers.
 */
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rxe_seq
    import rxe_pkg::*;
#(
    parameter int SYSTEM_RESET_OUTPUT_LEN = SYSTEM_RESET_OUTPUT_CYCLES
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // external reset pin
    input  wire logic        external_reset_input_n,
    output logic             system_reset_output,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // vector and prefetch read port
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_done,
    input  wire logic        bus_error_acknowledge,
    // execution unit fault reports
    input  wire logic        acc_valid,
    input  wire logic [1:0]  acc_kind,
    input  wire logic [1:0]  acc_beat,
    input  wire logic        acc_needed,
    input  wire logic        acc_xlat_fault,
    input  wire logic        acc_walk_fail,
    input  wire logic [31:0] acc_addr,
    input  wire logic        prefetch_used,
    input  wire logic        flow_change,
    input  wire logic        pipe_idle,
    input  wire logic        prefetch_busy,
    input  wire logic        other_exception,
    input  wire logic [31:0] exec_pc,
    input  wire logic        stack_busy,
    input  wire logic        reload_busy,
    input  wire logic        reset_instr,
    // sequencer outputs
    output logic [3:0]       processor_state_lines,
    output logic             abort_instr,
    output logic             running
);
    rxe_state_t  st_q;
    logic [1:0]  rsync_q;
    logic        rst_seen_q;
    logic [15:0] sword_q;
    logic [15:0] sword_copy_q;
    logic [31:0] vbase_q;
    logic [31:0] isp_q;
    logic [31:0] pc_q;
    logic [31:0] fpc_q;
    logic [15:0] xlat_q;
    logic [31:0] faddr_q;
    logic [31:0] fstat_q;
    logic        pend_q;
    logic        pend_xlat_q;
    logic [31:0] pend_addr_q;
    logic [2:0]  fill_q;
    logic [15:0] system_reset_output_q;
    logic [31:0] prdata_q;
    logic        fault_now;
    logic        data_fault;
    logic        take_pend;
    logic        in_exc;
    logic        apb_wr;
    logic        bad_addr;

    // pin synchroniser; only the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsync_q <= 2'h3;
        end else begin
            rsync_q <= {rsync_q[0], external_reset_input_n};
        end
    end

    logic rst_act;
    assign rst_act = !rsync_q[1];

    assign apb_wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign bad_addr = (paddr[1:0] != 2'h0) || (paddr > REG_FSWORD);
    assign pslverr = psel && penable && bad_addr;

    // immediate data faults; line beats past the first only if needed
    always_comb begin
        data_fault = 1'b0;
        if (acc_valid && (acc_kind == AK_DATA_WR)) begin
            data_fault = 1'b1;
        end else if (acc_valid && (acc_kind == AK_DATA_RD)) begin
            data_fault = 1'b1;
        end else if (acc_valid && (acc_kind == AK_LINE_RD)) begin
            data_fault = (acc_beat == 2'h0) || acc_needed;
        end
    end

    // an instruction fault waits for the pipe to drain
    assign take_pend = pend_q && prefetch_used && pipe_idle
                       && !other_exception;
    // translation faults let the prefetch cycle finish first
    assign fault_now = (data_fault && !(acc_xlat_fault && prefetch_busy))
                       || take_pend;
    assign abort_instr = data_fault && (st_q == RXE_RUN);
    assign in_exc = (st_q == RXE_VISP) || (st_q == RXE_VPC)
                    || (st_q == RXE_FILL) || (st_q == RXE_STACK)
                    || (st_q == RXE_VACC);

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= RXE_IDLE;
            rst_seen_q <= 1'b0;
            fill_q     <= 3'h0;
        end else if (rst_act) begin
            st_q       <= RXE_IDLE;
            rst_seen_q <= 1'b1;
            fill_q     <= 3'h0;
        end else begin
            unique case (st_q)
                RXE_IDLE: begin
                    // only leave idle once after reset release
                    if (rst_seen_q) begin
                        st_q       <= RXE_VISP;
                        rst_seen_q <= 1'b0;
                    end
                end
                RXE_VISP, RXE_VPC, RXE_VACC: begin
                    if (bus_error_acknowledge) begin
                        st_q <= RXE_HALT;
                    end else if (mem_done) begin
                        st_q <= (st_q == RXE_VISP) ? RXE_VPC : RXE_FILL;
                        fill_q <= 3'h0;
                    end
                end
                RXE_FILL: begin
                    if (bus_error_acknowledge) begin
                        st_q <= RXE_HALT;
                    end else if (mem_done) begin
                        fill_q <= fill_q + 3'h1;
                        if (fill_q == PREFETCH_LW - 3'h1) begin
                            st_q <= RXE_RUN;
                        end
                    end
                end
                RXE_RUN: begin
                    if (bus_error_acknowledge && reload_busy) begin
                        st_q <= RXE_HALT;
                    end else if (fault_now) begin
                        st_q <= RXE_STACK;
                    end
                end
                RXE_STACK: begin
                    if (bus_error_acknowledge) begin
                        st_q <= RXE_HALT;
                    end else if (!stack_busy) begin
                        st_q <= RXE_VACC;
                    end
                end
                RXE_HALT: begin
                    st_q <= RXE_HALT;
                end
            endcase
        end
    end

    // architectural state; reset values set while reset is held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sword_q <= SWORD_RST;
            vbase_q <= VBASE_RST;
            xlat_q  <= 16'h0000 | (16'h1 << XL_PAGE8K);
        end else if (rst_act) begin
            sword_q[SW_TRACE_HIGH] <= 1'b0;
            sword_q[SW_TRACE_LOW]  <= 1'b0;
            sword_q[SW_SUPER]      <= 1'b1;
            sword_q[SW_MASTER]     <= 1'b0;
            sword_q[SW_IPM_LO +: 3] <= IPM_MAX;
            vbase_q <= VBASE_RST;
            // cache enables, translation enable, transparent enables
            xlat_q  <= 16'h0000 | (16'h1 << XL_PAGE8K);
        end else if (st_q == RXE_RUN && fault_now) begin
            sword_q[SW_SUPER]      <= 1'b1;
            sword_q[SW_TRACE_HIGH] <= 1'b0;
            sword_q[SW_TRACE_LOW]  <= 1'b0;
        end else if (apb_wr && !bad_addr) begin
            if (paddr == REG_SWORD) begin
                sword_q <= pwdata[15:0];
            end
            if (paddr == REG_VBASE) begin
                vbase_q <= pwdata;
            end
            if (paddr == REG_XLAT) begin
                xlat_q <= pwdata[15:0];
            end
        end
    end

    // vector loads; reset saves nothing, fault saves the frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isp_q <= 32'h0000_0000;
            pc_q  <= 32'h0000_0000;
        end else if (mem_done && !bus_error_acknowledge) begin
            if (st_q == RXE_VISP) begin
                isp_q <= mem_rdata;
            end
            if (st_q == RXE_VPC || st_q == RXE_VACC) begin
                pc_q <= mem_rdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sword_copy_q <= 16'h0000;
            fpc_q        <= 32'h0000_0000;
            faddr_q      <= 32'h0000_0000;
            fstat_q      <= 32'h0000_0000;
        end else if (st_q == RXE_RUN && fault_now && !rst_act) begin
            sword_copy_q <= sword_q;
            fpc_q        <= exec_pc;
            faddr_q      <= take_pend ? pend_addr_q : acc_addr;
            // bit 0 marks a translation fault, vector offset above
            fstat_q <= {14'h0, VEC_ACCESS, 2'h0, 7'h0,
                        take_pend ? pend_xlat_q
                                  : (acc_xlat_fault || acc_walk_fail)};
        end
    end

    // deferred prefetch fault; a new report wins a same-cycle clear, except a clear by pin reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q      <= 1'b0;
            pend_xlat_q <= 1'b0;
            pend_addr_q <= 32'h0000_0000;
        end else if (acc_valid && acc_kind == AK_PREFETCH && !rst_act) begin
            pend_q      <= 1'b1;
            pend_xlat_q <= acc_xlat_fault || acc_walk_fail;
            pend_addr_q <= acc_addr;
        end else if (rst_act || flow_change || other_exception
                     || take_pend) begin
            pend_q <= 1'b0;
        end
    end

    // reset instruction: pulse to outside only, no internal effect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_reset_output_q <= 16'h0000;
        end else if (reset_instr && st_q == RXE_RUN) begin
            system_reset_output_q <= SYSTEM_RESET_OUTPUT_LEN[15:0];
        end else if (system_reset_output_q != 16'h0000) begin
            system_reset_output_q <= system_reset_output_q - 16'h1;
        end
    end
    assign system_reset_output = (system_reset_output_q != 16'h0000);

    // memory request; vector address is four times number, plus base for the access vector only
    always_comb begin
        mem_req  = 1'b0;
        mem_addr = 32'h0000_0000;
        unique case (st_q)
            RXE_VISP: begin
                mem_req  = 1'b1;
                mem_addr = {22'h0, VEC_RESET_ISP, 2'h0};
            end
            RXE_VPC: begin
                mem_req  = 1'b1;
                mem_addr = {22'h0, VEC_RESET_PC, 2'h0};
            end
            RXE_VACC: begin
                mem_req  = 1'b1;
                mem_addr = vbase_q + {22'h0, VEC_ACCESS, 2'h0};
            end
            RXE_FILL: begin
                mem_req  = 1'b1;
                mem_addr = pc_q + {27'h0, fill_q, 2'h0};
            end
            default: begin
                mem_req  = 1'b0;
                mem_addr = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        processor_state_lines = PST_RUN;
        if (st_q == RXE_HALT) begin
            processor_state_lines = PST_HALT;
        end else if (in_exc) begin
            processor_state_lines = PST_EXC;
        end
    end
    assign running = (st_q == RXE_RUN);

    // apb read data; caches and translation cache are never touched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                REG_CTRL:   prdata_q <= {31'h0, rst_seen_q};
                REG_STATUS: prdata_q <= {25'h0, pend_q, running,
                                         1'b0, processor_state_lines};
                REG_SWORD:  prdata_q <= {16'h0, sword_q};
                REG_VBASE:  prdata_q <= vbase_q;
                REG_ISP:    prdata_q <= isp_q;
                REG_PC:     prdata_q <= pc_q;
                REG_XLAT:   prdata_q <= {16'h0, xlat_q};
                REG_FADDR:  prdata_q <= faddr_q;
                REG_FSTAT:  prdata_q <= fstat_q;
                REG_FPC:    prdata_q <= fpc_q;
                REG_FSWORD: prdata_q <= {16'h0, sword_copy_q};
                default:    prdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign prdata = prdata_q;
endmodule : rxe_seq
`default_nettype wire

// file: tb/rxe_checker.sv
/* rxe_checker: port-level assertions for the exception sequencer.
   Assumes one clock and the asynchronous active-low presetn. */
`timescale 1ns/1ps
`default_nettype none
module rxe_checker
    import rxe_pkg::*;
#(
    parameter int SYSTEM_RESET_OUTPUT_LEN = SYSTEM_RESET_OUTPUT_CYCLES
) (
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // pins
    input wire logic       external_reset_input_n,
    input wire logic       system_reset_output,
    input wire logic [3:0] processor_state_lines,
    // fetch port
    input wire logic       mem_req,
    input wire logic       bus_error_acknowledge,
    // fault reports
    input wire logic       acc_valid,
    input wire logic [1:0] acc_kind,
    input wire logic [1:0] acc_beat,
    input wire logic       acc_needed,
    input wire logic       acc_xlat_fault,
    input wire logic       prefetch_used,
    input wire logic       prefetch_busy,
    input wire logic       running
);
    logic [15:0] hi_cnt_q;
    logic        hit;
    logic        rd_now;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt_q <= 16'h0;
        end else begin
            hi_cnt_q <= system_reset_output ? hi_cnt_q + 16'h1 : 16'h0;
        end
    end
    // no pending prefetch fault may fire in the same cycle
    assign hit    = running && acc_valid && !prefetch_used;
    assign rd_now = acc_kind == AK_DATA_RD || (acc_kind == AK_LINE_RD
                    && (acc_beat == 2'h0 || acc_needed));

    a_pin_stops_run: assert property (
        !external_reset_input_n [*5] |-> !running && !mem_req)
        else $error("sequencer ran under pin reset");
    a_system_reset_output_width: assert property (
        $fell(system_reset_output) |-> hi_cnt_q == 16'(SYSTEM_RESET_OUTPUT_LEN))
        else $error("reset output pulse has wrong width");
    a_write_faults: assert property (
        hit && acc_kind == AK_DATA_WR && !prefetch_busy |=> !running)
        else $error("write error not taken at once");
    a_read_faults: assert property (
        hit && rd_now && !prefetch_busy |=> !running)
        else $error("read error not taken at once");
    a_late_beat_quiet: assert property (
        hit && acc_kind == AK_LINE_RD && !rd_now |=> running)
        else $error("unneeded line beat raised a fault");
    a_prefetch_defer: assert property (
        hit && acc_kind == AK_PREFETCH |=> running)
        else $error("prefetch error taken before use");
    a_xlat_waits: assert property (
        hit && acc_xlat_fault && acc_kind != AK_PREFETCH && prefetch_busy
        |=> running)
        else $error("translation fault did not wait for prefetch");
    a_double_fault: assert property (
        mem_req && bus_error_acknowledge && external_reset_input_n
        |=> processor_state_lines == PST_HALT)
        else $error("fetch error did not halt");
    a_halt_quiet: assert property (
        processor_state_lines == PST_HALT |-> !mem_req && !running)
        else $error("halted sequencer still active");
endmodule : rxe_checker
`default_nettype wire

// file: tb/rxe_mem_model.sv
/* rxe_mem_model: memory partner on the vector and prefetch port.
   Answers each beat after lat wait cycles, errors beat number err_beat. */
`timescale 1ns/1ps
`default_nettype none
module rxe_mem_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // test controls
    input  wire logic [3:0]  lat,
    input  wire logic [7:0]  err_beat,
    input  wire logic        clr,
    // fetch port
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic [31:0]      mem_rdata,
    output logic             mem_done,
    output logic             bus_error_acknowledge
);
    logic [3:0]  wait_q;
    logic [7:0]  n_beat;
    logic [31:0] addr_log [0:15];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q                <= 4'h0;
            n_beat                <= 8'h0;
            mem_rdata             <= 32'h0;
            mem_done              <= 1'b0;
            bus_error_acknowledge <= 1'b0;
        end else begin
            mem_done              <= 1'b0;
            bus_error_acknowledge <= 1'b0;
            // data is only valid with mem_done; toggle it otherwise
            mem_rdata             <= ~mem_rdata;
            if (clr) begin
                n_beat <= 8'h0;
            end else if (mem_req && !mem_done && !bus_error_acknowledge) begin
                if (wait_q >= lat) begin
                    wait_q                <= 4'h0;
                    n_beat                <= n_beat + 8'h1;
                    addr_log[n_beat[3:0]] <= mem_addr;
                    if (n_beat == err_beat) begin
                        bus_error_acknowledge <= 1'b1;
                    end else begin
                        mem_done  <= 1'b1;
                        mem_rdata <= mem_addr + 32'h0000_1000;
                    end
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end else begin
                wait_q <= 4'h0;
            end
        end
    end
endmodule : rxe_mem_model
`default_nettype wire

// file: tb/rxe_seq_tb.sv
/* rxe_seq_tb: directed bench for the exception sequencer.
   Assumes rxe_mem_model on the fetch port and rxe_checker bound below. */
`timescale 1ns/1ps
`default_nettype none
module rxe_seq_tb
    import rxe_pkg::*;
();
    logic        pclk = 1'b0;
    logic        presetn, external_reset_input_n, system_reset_output;
    logic        psel, penable, pwrite, pready, pslverr, mem_req, mem_done;
    logic        bus_error_acknowledge, acc_valid, acc_needed, acc_xlat_fault;
    logic        acc_walk_fail, prefetch_used, flow_change, pipe_idle;
    logic        prefetch_busy, other_exception, stack_busy, reload_busy;
    logic        reset_instr, abort_instr, running, clr, err, abort_seen;
    logic [1:0]  acc_kind, acc_beat;
    logic [3:0]  processor_state_lines, lat;
    logic [7:0]  paddr, err_beat;
    logic [31:0] pwdata, prdata, mem_addr, mem_rdata, acc_addr, exec_pc, q;
    logic [31:0] boot_a [6] = '{32'h0, 32'h4, 32'h1004, 32'h1008,
                                32'h100c, 32'h1010};
    int          error_cnt = 0, cmp_count = 0, cyc = 0, n;

    rxe_seq #(.SYSTEM_RESET_OUTPUT_LEN(4)) uut (
        .pclk, .presetn, .external_reset_input_n, .system_reset_output,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .mem_req, .mem_addr, .mem_rdata, .mem_done, .bus_error_acknowledge,
        .acc_valid, .acc_kind, .acc_beat, .acc_needed, .acc_xlat_fault,
        .acc_walk_fail, .acc_addr, .prefetch_used, .flow_change, .pipe_idle,
        .prefetch_busy, .other_exception, .exec_pc, .stack_busy, .reload_busy,
        .reset_instr, .processor_state_lines, .abort_instr, .running
    );
    rxe_mem_model mdl (
        .pclk, .presetn, .lat, .err_beat, .clr, .mem_req, .mem_addr,
        .mem_rdata, .mem_done, .bus_error_acknowledge
    );

    always #5 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc++;
        if (abort_instr === 1'b1) begin
            abort_seen <= 1'b1;
        end
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        chk(32'(k < 20), 32'h1);
        // idle edge so a following call never re-drives psel at once
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd

    task automatic settle(input logic lvl);
        int k = 0;
        while (running !== lvl && k < 600) begin
            @(posedge pclk);
            k++;
        end
        chk(32'(running), 32'(lvl));
    endtask : settle

    task automatic tick(input int c);
        repeat (c) @(posedge pclk);
    endtask : tick

    task automatic pin_pulse();
        clr <= 1'b1;
        external_reset_input_n <= 1'b0;
        tick(6);
        chk(32'(running), 32'h0);
        {clr, external_reset_input_n} <= 2'b01;
    endtask : pin_pulse

    task automatic init_regs();
        pin_pulse();
        settle(1'b1);
        chk(32'(mdl.n_beat), 32'd6);
        rd(REG_SWORD, 32'h0000_2700);
        rd(REG_VBASE, 32'h0);
        rd(REG_XLAT, 32'h0000_4000);
    endtask : init_regs

    task automatic fault(input logic [1:0] k, input logic [1:0] b,
                         input logic x, input logic [31:0] a);
        {acc_valid, acc_kind, acc_beat, acc_xlat_fault, acc_addr} <=
            {1'b1, k, b, x, a};
        abort_seen <= 1'b0;
        tick(1);
        acc_valid <= 1'b0;
    endtask : fault

    task automatic results();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, acc_valid, acc_kind,
         acc_beat, acc_needed, acc_xlat_fault, acc_walk_fail, acc_addr,
         exec_pc, prefetch_used, flow_change, pipe_idle, prefetch_busy,
         other_exception, stack_busy, reload_busy, reset_instr, lat, clr} = '0;
        external_reset_input_n = 1'b1;
        err_beat = 8'hff;
        tick(10);
        presetn <= 1'b1;
        tick(1);
        init_regs();
        foreach (boot_a[i]) chk(mdl.addr_log[i], boot_a[i]);
        rd(REG_ISP, 32'h0000_1000);
        rd(REG_PC, 32'h0000_1004);
        rd(8'h2c, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, REG_XLAT, 32'h0000_8030);
        apb(1'b1, REG_VBASE, 32'h0000_0040);
        apb(1'b1, REG_SWORD, 32'h0000_2300);
        reset_instr <= 1'b1;
        tick(1);
        reset_instr <= 1'b0;
        n = 0;
        repeat (12) begin
            tick(1);
            n += int'(system_reset_output === 1'b1);
        end
        chk(32'(n), 32'd4);
        rd(REG_SWORD, 32'h0000_2300);
        init_regs();
        lat <= 4'h3;
        apb(1'b1, REG_VBASE, 32'h0000_0100);
        apb(1'b1, REG_SWORD, 32'h0000_c000);
        {clr, exec_pc} <= {1'b1, 32'h0000_4444};
        tick(1);
        clr <= 1'b0;
        fault(AK_DATA_WR, 2'h0, 1'b0, 32'h0000_5550);
        settle(1'b0);
        settle(1'b1);
        chk(mdl.addr_log[0], 32'h0000_0108);
        chk(mdl.addr_log[4], 32'h0000_1114);
        chk(32'(abort_seen), 32'h1);
        rd(REG_PC, 32'h0000_1108);
        rd(REG_FADDR, 32'h0000_5550);
        rd(REG_FPC, 32'h0000_4444);
        rd(REG_FSWORD, 32'h0000_c000);
        rd(REG_SWORD, 32'h0000_2000);
        rd(REG_FSTAT, 32'h0000_0800);
        fault(AK_LINE_RD, 2'h2, 1'b0, 32'h0000_6668);
        tick(4);
        chk(32'(running), 32'h1);
        chk(32'(abort_seen), 32'h0);
        acc_needed <= 1'b1;
        fault(AK_LINE_RD, 2'h3, 1'b0, 32'h0000_666c);
        settle(1'b0);
        settle(1'b1);
        acc_needed <= 1'b0;
        {prefetch_busy, acc_walk_fail} <= 2'b11;
        // the unit keeps reporting the fault while the prefetch runs
        {acc_valid, acc_kind, acc_xlat_fault, acc_addr} <=
            {1'b1, AK_DATA_RD, 1'b1, 32'h0000_7770};
        tick(3);
        chk(32'(running), 32'h1);
        {prefetch_busy, acc_walk_fail} <= 2'b00;
        tick(1);
        acc_valid <= 1'b0;
        settle(1'b0);
        settle(1'b1);
        rd(REG_FSTAT, 32'h0000_0801);
        rd(REG_FADDR, 32'h0000_7770);
        fault(AK_PREFETCH, 2'h0, 1'b0, 32'h0000_9990);
        tick(3);
        chk(32'(running), 32'h1);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(q & 32'h40, 32'h40);
        flow_change <= 1'b1;
        tick(1);
        {flow_change, prefetch_used, pipe_idle} <= 3'b011;
        tick(4);
        chk(32'(running), 32'h1);
        {prefetch_used, pipe_idle, other_exception} <= 3'b001;
        fault(AK_PREFETCH, 2'h0, 1'b0, 32'h0000_9994);
        {prefetch_used, pipe_idle} <= 2'b11;
        tick(4);
        chk(32'(running), 32'h1);
        {prefetch_used, pipe_idle, other_exception} <= 3'b000;
        fault(AK_PREFETCH, 2'h0, 1'b0, 32'h0000_9998);
        {prefetch_used, pipe_idle} <= 2'b11;
        settle(1'b0);
        settle(1'b1);
        {prefetch_used, pipe_idle} <= 2'b00;
        rd(REG_FADDR, 32'h0000_9998);
        lat <= 4'h0;
        pin_pulse();
        settle(1'b1);
        {clr, err_beat} <= {1'b1, 8'h00};
        tick(1);
        clr <= 1'b0;
        fault(AK_DATA_WR, 2'h0, 1'b0, 32'h0000_5554);
        tick(12);
        chk(32'(processor_state_lines), 32'(PST_HALT));
        err_beat <= 8'h01;
        pin_pulse();
        tick(20);
        chk(32'(processor_state_lines), 32'(PST_HALT));
        err_beat <= 8'hff;
        init_regs();
        chk(32'(processor_state_lines), 32'(PST_RUN));
        rd(REG_FPC, 32'h0000_4444);
        results();
    end
endmodule : rxe_seq_tb

bind rxe_seq rxe_checker #(.SYSTEM_RESET_OUTPUT_LEN(SYSTEM_RESET_OUTPUT_LEN)) u_chk (
    .pclk, .presetn, .external_reset_input_n, .system_reset_output,
    .processor_state_lines, .mem_req, .bus_error_acknowledge, .acc_valid,
    .acc_kind, .acc_beat, .acc_needed, .acc_xlat_fault, .prefetch_used,
    .prefetch_busy, .running
);
`default_nettype wire
